// File: verilog/abrp_top.sv
`timescale 1ns/100ps
module abrp_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_upper_byte_select,
  input wire logic i_special_function_select,
  input wire logic [11:0] i_result,
  input wire logic [7:0] i_special_reg,
  input wire logic i_conv_active,
  input wire logic [7:0] i_host_data_lines,
  output logic [7:0] o_host_data_lines,
  output logic [7:0] o_host_data_lines_oe_n,
  output logic o_busy_n
);
  import abrp_pkg::*;

  abrp_host_t pins_raw;
  abrp_host_t pins;
  abrp_top_t t_reg;
  abrp_top_t t_next;
  logic read_on;

  // Pin strobes into the clock domain
  assign pins_raw = '{cs_n: i_cs_n, rd_n: i_rd_n,
    upper_byte_select: i_upper_byte_select,
    special_function_select: i_special_function_select};

  abrp_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pins(pins_raw),
    .o_pins(pins)
  );

  // Byte presented to the host
  function automatic logic [7:0] abrp_byte(input logic spec_sel, input logic hi,
      input logic [11:0] res, input logic [7:0] spec, input logic active);
    logic [7:0] b;
    b = ABRP_DATA_RST;
    if (spec_sel) begin
      b = spec;
    end else if (hi) begin
      b[ABRP_HI_NIBBLE_W-1:0] = res[ABRP_RES_W-1:ABRP_HI_RES_LSB];
      b[ABRP_HI_STATUS_BIT-1:ABRP_HI_NIBBLE_W] = ABRP_HI_PAD;
      b[ABRP_HI_STATUS_BIT] = active;
    end else begin
      b = res[ABRP_DATA_W-1:0];
    end
    return b;
  endfunction

  assign read_on = !pins.cs_n && !pins.rd_n;

  // Next state
  always_comb begin
    t_next = t_reg;
    t_next.busy_n = !i_conv_active;
    t_next.data = abrp_byte(pins.special_function_select,
      pins.upper_byte_select, i_result, i_special_reg, i_conv_active);
    unique case (t_reg.state)
      ABRP_IDLE: begin
        t_next.oe_n = ABRP_OE_RST;
        if (read_on) begin
          t_next.state = ABRP_DRIVE;
          t_next.oe_n = ~ABRP_OE_RST;
        end
      end
      ABRP_DRIVE: begin
        if (!read_on) begin
          t_next.state = ABRP_IDLE;
          t_next.oe_n = ABRP_OE_RST;
        end
      end
      default: begin
        t_next.state = ABRP_IDLE;
        t_next.oe_n = ABRP_OE_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      t_reg <= '{state: ABRP_IDLE, data: ABRP_DATA_RST, oe_n: ABRP_OE_RST,
        busy_n: 1'b1};
    end else begin
      t_reg <= t_next;
    end
  end

  assign o_host_data_lines = t_reg.data;
  assign o_host_data_lines_oe_n = t_reg.oe_n;
  assign o_busy_n = t_reg.busy_n;

  // Checks
  property p_special_route;
    @(posedge i_clk) disable iff (i_rst)
    pins.special_function_select |=> o_host_data_lines == $past(i_special_reg);
  endproperty
  a_special_route: assert property (p_special_route) else $error("register not routed");

  property p_low_byte;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && !pins.upper_byte_select
      |=> o_host_data_lines == $past(i_result[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

  property p_hi_nibble;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && pins.upper_byte_select
      |=> o_host_data_lines[3:0] == $past(i_result[11:8]);
  endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("high nibble wrong");

  property p_bit9;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && pins.upper_byte_select
      |=> o_host_data_lines[1] == $past(i_result[9]);
  endproperty
  a_bit9: assert property (p_bit9) else $error("line 1 not bit 9");

  property p_pad;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && pins.upper_byte_select
      |=> o_host_data_lines[6:4] == 3'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("pad lines not low");

  property p_status;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && pins.upper_byte_select
      |=> o_host_data_lines[7] == !o_busy_n;
  endproperty
  a_status: assert property (p_status) else $error("status not inverse busy");

  // Status flag straight from the converter state
  property p_status_conv;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && pins.upper_byte_select && i_conv_active
      |=> o_host_data_lines[7];
  endproperty
  a_status_conv: assert property (p_status_conv) else $error("status low while busy");

  property p_status_done;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select && pins.upper_byte_select && !i_conv_active
      |=> !o_host_data_lines[7];
  endproperty
  a_status_done: assert property (p_status_done) else $error("status high when done");

  property p_result_map;
    @(posedge i_clk) disable iff (i_rst)
    !pins.special_function_select |=> o_host_data_lines == ($past(pins.upper_byte_select)
      ? {$past(i_conv_active), 3'h0, $past(i_result[11:8])} : $past(i_result[7:0]));
  endproperty
  a_result_map: assert property (p_result_map) else $error("result map wrong");

  property p_drive;
    @(posedge i_clk) disable iff (i_rst)
    read_on && t_reg.state == ABRP_IDLE |=> o_host_data_lines_oe_n == 8'h00
      ##1 (!$past(read_on) || o_host_data_lines_oe_n == 8'h00);
  endproperty
  a_drive: assert property (p_drive) else $error("read not driven");

  property p_release;
    @(posedge i_clk) disable iff (i_rst)
    !read_on |=> o_host_data_lines_oe_n == 8'hFF;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  // Pin to bus latency, two sync stages plus the output register
  property p_access_time;
    @(posedge i_clk) disable iff (i_rst)
    (!i_cs_n && !i_rd_n) [*2]
      |-> ##2 o_host_data_lines_oe_n == 8'h00;
  endproperty
  a_access_time: assert property (p_access_time) else $error("read not answered");

  property p_release_time;
    @(posedge i_clk) disable iff (i_rst)
    i_cs_n [*2]
      |-> ##2 o_host_data_lines_oe_n == 8'hFF;
  endproperty
  a_release_time: assert property (p_release_time) else $error("release late");

  property p_busy;
    @(posedge i_clk) disable iff (i_rst)
    i_conv_active |=> !o_busy_n;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not low");

  property p_busy_high;
    @(posedge i_clk) disable iff (i_rst)
    !i_conv_active
      |=> o_busy_n;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("busy not high");

  c_low_read: cover property (@(posedge i_clk) read_on && !pins.upper_byte_select);
  c_hi_read: cover property (@(posedge i_clk) read_on && pins.upper_byte_select);
  c_special_read: cover property (@(posedge i_clk) read_on && pins.special_function_select);
  c_upper_busy: cover property (@(posedge i_clk) read_on && pins.upper_byte_select && i_conv_active);
  c_conv_end: cover property (@(posedge i_clk) $fell(i_conv_active));
endmodule

// File: include/abrp_pkg.sv
package abrp_pkg;
  // Widths of the port
  localparam int ABRP_RES_W = 12;
  localparam int ABRP_DATA_W = 8;
  localparam int ABRP_SPECIAL_W = 8;
  // Upper byte layout
  localparam int ABRP_HI_STATUS_BIT = 7;
  localparam int ABRP_HI_RES_LSB = 8;
  localparam int ABRP_HI_NIBBLE_W = 4;
  localparam logic [2:0] ABRP_HI_PAD = 3'h0;
  // Reset values
  localparam logic [7:0] ABRP_DATA_RST = 8'h00;
  localparam logic [7:0] ABRP_OE_RST = 8'hFF;

  // Host strobes, sampled from pins
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic upper_byte_select;
    logic special_function_select;
  } abrp_host_t;

  // Read port state machine
  typedef enum logic [1:0] {
    ABRP_IDLE = 2'b00,
    ABRP_DRIVE = 2'b01
  } abrp_state_t;

  // Whole state of the top module
  typedef struct packed {
    abrp_state_t state;
    logic [7:0] data;
    logic [7:0] oe_n;
    logic busy_n;
  } abrp_top_t;
endpackage

// File: verilog/abrp_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for the host strobe pins
module abrp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire abrp_pkg::abrp_host_t i_pins,
  output abrp_pkg::abrp_host_t o_pins
);
  import abrp_pkg::*;

  typedef struct packed {
    abrp_host_t meta;
    abrp_host_t sync;
  } abrp_sync_t;

  abrp_sync_t s_reg;
  abrp_sync_t s_next;

  // Idle strobes high, selects low
  localparam abrp_host_t ABRP_HOST_IDLE = '{cs_n: 1'b1, rd_n: 1'b1,
    upper_byte_select: 1'b0, special_function_select: 1'b0};

  // Shift chain
  always_comb begin
    s_next.meta = i_pins;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '{meta: ABRP_HOST_IDLE, sync: ABRP_HOST_IDLE};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_pins = s_reg.sync;
endmodule

// File: verif/abrp_host.sv
`timescale 1ns/100ps
// Host bus model on the read port
module abrp_host (
  input wire logic i_clk,
  input wire logic [7:0] i_bus,
  input wire logic [7:0] i_oe_n,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_ubs,
  output logic o_sfs
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_ubs = 1'b0;
    o_sfs = 1'b0;
  end
  // both strobes held low until the bus is driven
  task automatic read(input logic ubs, input logic sfs, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    o_ubs <= ubs;
    o_sfs <= sfs;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_oe_n !== 8'h00 && n < 20);
    d = i_bus;
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    // Wait for release so a following read cannot see the old drive
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_oe_n !== 8'hFF && n < 20);
  endtask
  // One strobe only, held for a while
  task automatic hold(input logic cs, input logic rd);
    @(posedge i_clk);
    o_cs_n <= cs;
    o_rd_n <= rd;
    repeat (6) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
  endtask
endmodule

// File: verif/tb_abrp_top.sv
`timescale 1ns/100ps
module tb_abrp_top;
  logic i_clk, i_rst, cs_n, rd_n, ubs, sfs, active, busy_n;
  logic [11:0] result;
  logic [7:0] spec, data, oe_n, bus, got;
  int miscompares = 0;
  int total_checks = 0;
  abrp_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_upper_byte_select(ubs), .i_special_function_select(sfs), .i_result(result),
    .i_special_reg(spec), .i_conv_active(active), .i_host_data_lines(bus),
    .o_host_data_lines(data), .o_host_data_lines_oe_n(oe_n), .o_busy_n(busy_n));
  abrp_host host (.i_clk(i_clk), .i_bus(bus), .i_oe_n(oe_n), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_ubs(ubs), .o_sfs(sfs));
  // Released lines show the inverse of the last byte
  assign bus = (oe_n === 8'h00) ? data : ~data;
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_bytes;
    for (int a = 0; a < 2; a++) begin
      active <= a[0];
      host.read(1'b0, 1'b0, got);
      chk("low byte", 8'hC3, got);
      host.read(1'b1, 1'b0, got);
      chk("high byte", {a[0], 7'h05}, got);
    end
    repeat (4) @(posedge i_clk);
    chk("release", 8'hFF, oe_n);
    $display("test bytes done");
  endtask
  task automatic t_special;
    host.read(1'b0, 1'b1, got);
    chk("special low", 8'h3C, got);
    host.read(1'b1, 1'b1, got);
    chk("special high", 8'h3C, got);
    $display("test special done");
  endtask
  task automatic t_refuse;
    host.hold(1'b0, 1'b1);
    chk("cs only", 8'hFF, oe_n);
    host.hold(1'b1, 1'b0);
    chk("rd only", 8'hFF, oe_n);
    $display("test refuse done");
  endtask
  task automatic t_busy;
    active <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("busy low", 8'h00, {7'h00, busy_n});
    active <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("busy high", 8'h01, {7'h00, busy_n});
    $display("test busy done");
  endtask
  initial begin
    i_rst = 1'b1;
    active = 1'b0;
    result = 12'h5C3;
    spec = 8'h3C;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    t_bytes();
    t_special();
    t_refuse();
    t_busy();
    summarize();
  end
  initial begin
    repeat (2000) @(posedge i_clk);
    miscompares++;
    summarize();
  end
endmodule
